// [rtl/sscr_top.sv]
/*
 * Write-only configuration register bank of a fractional-N synthesizer.
 * Words arrive over the three-wire serial port, are steered by their low
 * four bits and either take effect at once or wait in a shadow stage for
 * the next integer divide word. Active words and key fields are outputs.
 * Assumes the analog and calibration logic downstream reads the outputs.
 */
`timescale 1ns/1ps

// How it works
// - Shift MSB first, transfer on strobe rise
// - Low four bits select registers 0-12
// - Shadowed fields apply on next word 0
// - Divider select shadowed only if enabled
// - Word 2 top 14 bits shadowed numerator
// - Word 9 holds timeout and timing fields
// - Word 12 holds resync clock timer
// - Word 9 fields sit above code
// - Word 10 controls above code bits
// - Word 0 with autocal bit starts calibration
module sscr_top
(
    input  wire logic              MCLK_I,          // System clock.
    input  wire logic              RST_N_I,         // Async reset, low.
    input  wire logic              SER_CLK_I,       // Serial clock pin.
    input  wire logic              SER_DATA_I,      // Serial data pin.
    input  wire logic              LATCH_STROBE_I,  // Latch strobe pin.
    output logic [12:0][31:0]      ACTIVE_WORDS_O,  // Words in effect.
    output logic                   WORD_TAKEN_O,    // Valid word pulse.
    output logic                   AUTOCAL_START_O, // Calibration pulse.
    output logic [13:0]            AUX_FRAC_O,      // Aux numerator.
    output logic [7:0]             BAND_SEL_TIME_O, // Band select time.
    output logic [9:0]             LOCK_TIMEOUT_O,  // Lock timeout.
    output logic [4:0]             ALC_WAIT_O,      // Level wait.
    output logic [4:0]             SYNTH_WAIT_O,    // Synth lock wait.
    output logic [7:0]             CONV_CLK_DIV_O,  // Converter divider.
    output logic                   CONV_ENABLE_O,   // Converter enable.
    output logic                   CONV_REQUEST_O,  // Conversion request.
    output logic [19:0]            RESYNC_CLOCK_O   // Resync timer.
);

    logic [31:0]        word;            // Word from the serial front end.
    logic               load;            // Latch event from the front end.
    logic [3:0]         code;            // Destination code of the word.
    logic               code_ok;         // Code names a real register.
    logic               commit;          // Valid integer divide word.
    logic [12:0][31:0]  eff_mask;        // Held-back bits per register.
    logic [12:0][31:0]  commit_mask;     // Bits that word 0 releases.
    logic [12:0][31:0]  held_ff;         // Shadow stage, as written.
    logic [12:0][31:0]  nxt_held;        // Next shadow stage.
    logic [12:0][31:0]  active_ff;       // Values in effect.
    logic [12:0][31:0]  nxt_active;      // Next values in effect.
    logic               taken_ff;        // Registered accept pulse.
    logic               nxt_taken;       // Next accept pulse.
    logic               autocal_ff;      // Registered calibration pulse.
    logic               nxt_autocal;     // Next calibration pulse.

    // Pin synchronisation and shifting live in the front end.
    sscr_shifter u_shifter
    (
        .clk_i    (MCLK_I),
        .rst_n_i  (RST_N_I),
        .sclk_i   (SER_CLK_I),
        .sdata_i  (SER_DATA_I),
        .strobe_i (LATCH_STROBE_I),
        .word_o   (word),
        .load_o   (load)
    );

    assign code    = word[3:0];
    assign code_ok = (code <= sscr_pkg::CODE_LAST);
    assign commit  = load && code_ok && (code == sscr_pkg::CODE_INT_DIV);

    // Per-register mask of held-back bits. Only word 6 has a conditional
    // part; its enable is the reference path bit already in effect, so a
    // change to it never races the word it governs.
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi++)
        begin : g_mask
            if (gi == sscr_pkg::IDX_OUT_STAGE)
            begin : g_cond
                assign eff_mask[gi] = sscr_pkg::DB_MASK[gi] |
                    (active_ff[sscr_pkg::IDX_REF_PATH][sscr_pkg::DBUF_EN_BIT]
                     ? sscr_pkg::DBB_MASK : 32'h0000_0000);
                // Word 0 always releases the divider select. A value held
                // while buffering was on is not lost if buffering is then
                // switched off; with buffering off the shadow equals the
                // active value, so the release changes nothing.
                assign commit_mask[gi] = sscr_pkg::DB_MASK[gi] |
                                         sscr_pkg::DBB_MASK;
            end
            else
            begin : g_plain
                assign eff_mask[gi]    = sscr_pkg::DB_MASK[gi];
                assign commit_mask[gi] = sscr_pkg::DB_MASK[gi];
            end
        end
    endgenerate

    // Next values of the shadow and active stages. The shadow keeps the
    // whole word; only masked bits are ever read from it, which costs
    // some flops but keeps the commit a single uniform merge.
    always_comb
    begin
        nxt_held    = held_ff;
        nxt_active  = active_ff;
        nxt_taken   = 1'b0;
        nxt_autocal = 1'b0;
        if (commit)
        begin
            for (int r = 0; r < 13; r++)
            begin
                nxt_active[r] = (active_ff[r] & ~commit_mask[r]) |
                                (held_ff[r] & commit_mask[r]);
            end
        end
        if (load && code_ok)
        begin
            nxt_taken        = 1'b1;
            nxt_held[code]   = word;
            // Unmasked bits take effect at once; masked ones wait.
            nxt_active[code] = (nxt_active[code] & eff_mask[code]) |
                               (word & ~eff_mask[code]);
        end
        if (commit && word[sscr_pkg::AUTOCAL_BIT])
        begin
            nxt_autocal = 1'b1;
        end
    end

    // Registers only; everything clears to a constant on reset.
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            held_ff    <= {13{sscr_pkg::WORD_RESET}};
            active_ff  <= {13{sscr_pkg::WORD_RESET}};
            taken_ff   <= 1'b0;
            autocal_ff <= 1'b0;
        end
        else
        begin
            held_ff    <= nxt_held;
            active_ff  <= nxt_active;
            taken_ff   <= nxt_taken;
            autocal_ff <= nxt_autocal;
        end
    end

    // Outputs are the active stage, its slices and the pulse flops, so they come from flops.
    assign ACTIVE_WORDS_O  = active_ff;
    assign WORD_TAKEN_O    = taken_ff;
    assign AUTOCAL_START_O = autocal_ff;
    assign AUX_FRAC_O      = active_ff[sscr_pkg::IDX_AUX_FRAC]
                             [sscr_pkg::AUX_FRAC_HI:sscr_pkg::AUX_FRAC_LO];
    assign BAND_SEL_TIME_O = active_ff[sscr_pkg::IDX_CAL_TIME]
                             [sscr_pkg::BAND_SEL_HI:sscr_pkg::BAND_SEL_LO];
    assign LOCK_TIMEOUT_O  = active_ff[sscr_pkg::IDX_CAL_TIME]
                             [sscr_pkg::LOCK_TMO_HI:sscr_pkg::LOCK_TMO_LO];
    assign ALC_WAIT_O      = active_ff[sscr_pkg::IDX_CAL_TIME]
                             [sscr_pkg::ALC_WAIT_HI:sscr_pkg::ALC_WAIT_LO];
    assign SYNTH_WAIT_O    = active_ff[sscr_pkg::IDX_CAL_TIME]
                             [sscr_pkg::SYN_WAIT_HI:sscr_pkg::SYN_WAIT_LO];
    assign CONV_CLK_DIV_O  = active_ff[sscr_pkg::IDX_CONV]
                             [sscr_pkg::CONV_DIV_HI:sscr_pkg::CONV_DIV_LO];
    assign CONV_ENABLE_O   = active_ff[sscr_pkg::IDX_CONV]
                             [sscr_pkg::CONV_EN_BIT];
    assign CONV_REQUEST_O  = active_ff[sscr_pkg::IDX_CONV]
                             [sscr_pkg::CONV_REQ_BIT];
    assign RESYNC_CLOCK_O  = active_ff[sscr_pkg::IDX_RESYNC]
                             [sscr_pkg::RESYNC_HI:sscr_pkg::RESYNC_LO];

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_ignore_code;
        load && (word[3:0] > 4'hc) |=> $stable(active_ff) && $stable(held_ff)
            && !taken_ff;
    endproperty
    a_ignore_code: assert property (p_ignore_code)
        else $error("Word with unused code changed the registers.");

    property p_shadow_wait;
        load && word[3:0] == 4'h1 |=>
            (active_ff[1] & sscr_pkg::DB_MASK[1]) ==
            ($past(active_ff[1]) & sscr_pkg::DB_MASK[1])
            && held_ff[1] == $past(word);
    endproperty
    a_shadow_wait: assert property (p_shadow_wait)
        else $error("Shadowed word took effect before word 0.");

    property p_commit;
        load && word[3:0] == 4'h0 |=> active_ff[1] == $past(held_ff[1])
            && active_ff[0] == $past(word);
    endproperty
    a_commit: assert property (p_commit)
        else $error("Word 0 did not release the shadowed word.");

    property p_aux_frac;
        load && word[3:0] == 4'h0
            |=> AUX_FRAC_O == $past(held_ff[2][31:18]);
    endproperty
    a_aux_frac: assert property (p_aux_frac)
        else $error("Aux numerator not released by word 0.");

    property p_aux_hold;
        load && word[3:0] == 4'h2 |=> $stable(AUX_FRAC_O);
    endproperty
    a_aux_hold: assert property (p_aux_hold)
        else $error("Aux numerator changed before word 0.");

    property p_immediate;
        load && word[3:0] == 4'h5 |=> active_ff[5] == $past(word);
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("Unshadowed word did not take effect at once.");

    property p_div_now;
        load && word[3:0] == 4'h6 && !active_ff[4][14]
            |=> active_ff[6][23:21] == $past(word[23:21]);
    endproperty
    a_div_now: assert property (p_div_now)
        else $error("Divider select held back while buffering is off.");

    property p_div_held;
        load && word[3:0] == 4'h6 && active_ff[4][14]
            |=> active_ff[6][23:21] == $past(active_ff[6][23:21]);
    endproperty
    a_div_held: assert property (p_div_held)
        else $error("Divider select applied while buffering is on.");

    property p_autocal;
        load && word[3:0] == 4'h0 && word[21] |=> AUTOCAL_START_O ##1
            !AUTOCAL_START_O;
    endproperty
    a_autocal: assert property (p_autocal)
        else $error("Calibration pulse missing or too long.");

    property p_autocal_cause;
        AUTOCAL_START_O |-> $past(load) && $past(word[3:0]) == 4'h0
            && $past(word[21]);
    endproperty
    a_autocal_cause: assert property (p_autocal_cause)
        else $error("Calibration pulse without a word 0.");

    c_commit: cover property (load && word[3:0] == 4'h2 ##[1:300] commit);
    c_autocal: cover property (AUTOCAL_START_O);
    c_div_held: cover property (load && word[3:0] == 4'h6 && active_ff[4][14]);
    c_bad_code: cover property (load && word[3:0] == 4'hf);

endmodule

// [rtl/sscr_pkg.sv]
/*
 * Shared constants of the serial configuration register bank: word
 * geometry, destination codes, field positions and the masks that mark
 * which bits wait for the next integer divide word before taking effect.
 * Assumes it is compiled before every file that names it.
 */
package sscr_pkg;

    // Geometry of a programming word.
    localparam int unsigned WORD_W   = 32;
    localparam int unsigned CODE_W   = 4;
    localparam int unsigned NUM_REGS = 13;

    // Destination codes that matter to the logic.
    localparam logic [3:0] CODE_INT_DIV   = 4'h0;
    localparam logic [3:0] CODE_REF_PATH  = 4'h4;
    localparam logic [3:0] CODE_OUT_STAGE = 4'h6;
    localparam logic [3:0] CODE_LAST      = 4'hc;

    // Index form of the same destinations, for array selects.
    localparam int unsigned IDX_AUX_FRAC  = 2;
    localparam int unsigned IDX_REF_PATH  = 4;
    localparam int unsigned IDX_OUT_STAGE = 6;
    localparam int unsigned IDX_CAL_TIME  = 9;
    localparam int unsigned IDX_CONV      = 10;
    localparam int unsigned IDX_RESYNC    = 12;

    // Control bits inside words.
    localparam int unsigned AUTOCAL_BIT   = 21;
    localparam int unsigned DBUF_EN_BIT   = 14;

    // Field positions: auxiliary fraction numerator in word 2.
    localparam int unsigned AUX_FRAC_HI   = 31;
    localparam int unsigned AUX_FRAC_LO   = 18;
    // Calibration timing word 9.
    localparam int unsigned BAND_SEL_HI   = 31;
    localparam int unsigned BAND_SEL_LO   = 24;
    localparam int unsigned LOCK_TMO_HI   = 23;
    localparam int unsigned LOCK_TMO_LO   = 14;
    localparam int unsigned ALC_WAIT_HI   = 13;
    localparam int unsigned ALC_WAIT_LO   = 9;
    localparam int unsigned SYN_WAIT_HI   = 8;
    localparam int unsigned SYN_WAIT_LO   = 4;
    // Converter control word 10.
    localparam int unsigned CONV_DIV_HI   = 13;
    localparam int unsigned CONV_DIV_LO   = 6;
    localparam int unsigned CONV_REQ_BIT  = 5;
    localparam int unsigned CONV_EN_BIT   = 4;
    // Resync timer word 12.
    localparam int unsigned RESYNC_HI     = 31;
    localparam int unsigned RESYNC_LO     = 12;

    // Reset value of every stored word.
    localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

    // Bits held back until the next integer divide word, per register.
    localparam logic [12:0][31:0] DB_MASK = {
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h07ff_bc00, 32'h0fff_fff0, 32'hffff_fff0, 32'h0fff_fff0,
        32'h0000_0000};

    // Divider select bits of word 6, held back only when enabled.
    localparam logic [31:0] DBB_MASK      = 32'h00e0_0000;

endpackage

// [rtl/sscr_shifter.sv]
/*
 * Serial front end: brings the three programming pins into the system
 * clock domain, shifts data in on each serial clock rise and reports a
 * whole word on each latch strobe rise.
 * Assumes the serial clock is much slower than the system clock so that
 * every serial edge is seen after synchronisation.
 */
`timescale 1ns/1ps

module sscr_shifter
(
    input  wire logic        clk_i,      // System clock.
    input  wire logic        rst_n_i,    // Asynchronous reset, active low.
    input  wire logic        sclk_i,     // Serial clock pin.
    input  wire logic        sdata_i,    // Serial data pin.
    input  wire logic        strobe_i,   // Latch strobe pin.
    output logic      [31:0] word_o,     // Last full word shifted in.
    output logic             load_o      // One-cycle pulse per latch.
);

    // Two-flop synchronisers plus one delay stage for edge finding.
    logic [2:0]  sclk_ff;                // Serial clock sync chain.
    logic [2:0]  strobe_ff;              // Strobe sync chain.
    logic [1:0]  sdata_ff;               // Data sync chain.
    logic [31:0] shift_ff;               // Shift register.
    logic [31:0] nxt_shift;              // Next shift register value.
    logic [31:0] word_ff;                // Word captured at the latch.
    logic [31:0] nxt_word;               // Next captured word.
    logic        load_ff;                // Registered load pulse.
    logic        nxt_load;               // Next load pulse.
    logic        sclk_rise;              // Serial clock rose.
    logic        strobe_rise;            // Strobe rose.

    // Edges are taken between the second and third stages only, so the
    // first flop of each chain feeds nothing but the second.
    assign sclk_rise   = sclk_ff[1] & ~sclk_ff[2];
    assign strobe_rise = strobe_ff[1] & ~strobe_ff[2];

    // Next-state logic for the shifter and the captured word.
    always_comb
    begin
        nxt_shift = shift_ff;
        nxt_word  = word_ff;
        nxt_load  = 1'b0;
        if (sclk_rise)
        begin
            nxt_shift = {shift_ff[30:0], sdata_ff[1]};
        end
        if (strobe_rise)
        begin
            nxt_word = shift_ff;
            nxt_load = 1'b1;
        end
    end

    // Registers only; reset takes constants.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sclk_ff   <= 3'h0;
            strobe_ff <= 3'h0;
            sdata_ff  <= 2'h0;
            shift_ff  <= 32'h0000_0000;
            word_ff   <= 32'h0000_0000;
            load_ff   <= 1'b0;
        end
        else
        begin
            sclk_ff   <= {sclk_ff[1:0], sclk_i};
            strobe_ff <= {strobe_ff[1:0], strobe_i};
            sdata_ff  <= {sdata_ff[0], sdata_i};
            shift_ff  <= nxt_shift;
            word_ff   <= nxt_word;
            load_ff   <= nxt_load;
        end
    end

    assign word_o = word_ff;
    assign load_o = load_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_shift_in;
        sclk_rise |=> shift_ff == {$past(shift_ff[30:0]), $past(sdata_ff[1])};
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("Serial bit not shifted in at the low end.");

    property p_latch_word;
        strobe_rise |=> load_ff && word_ff == $past(shift_ff);
    endproperty
    a_latch_word: assert property (p_latch_word)
        else $error("Latch strobe did not capture the shifted word.");

endmodule

// [verif/sscr_host_model.sv]
/*
 * Host model for the three-wire programming port: shifts each word out
 * MSB first and raises the latch strobe after the last bit.
 * Assumes a free running system clock; pins change just after its rise.
 */
`timescale 1ns/1ps

module sscr_host_model
(
    input  wire logic clk_i,      // System clock used for pacing.
    output logic      ser_clk_o,  // Serial clock, low outside frames.
    output logic      ser_data_o, // Serial data pin.
    output logic      strobe_o    // Latch strobe pin.
);
    // Idle pins, so that a reset release sees no serial edge.
    initial
    begin
        ser_clk_o  = 1'b0;
        ser_data_o = 1'b0;
        strobe_o   = 1'b0;
    end

    // Every level lasts four system cycles, longer than the shortest one accepted.
    // MSB first, whole word
    // Reserved patterns of words 8 and 11 are sent as the caller gives.
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge clk_i);
            ser_clk_o  <= 1'b0;
            ser_data_o <= w[i];
            repeat (4) @(posedge clk_i);
            ser_clk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
        @(posedge clk_i);
        ser_clk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        strobe_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        strobe_o <= 1'b0;
        // A released line must not keep showing the last bit.
        ser_data_o <= ~w[0];
    endtask
endmodule

// [verif/test_synth_serial_config_registers.sv]
/*
 * Self-checking bench of the serial configuration register bank: random
 * and directed words through the host model, checked against a model
 * of the active and shadow words.
 * Assumes the host model and the package are compiled before it.
 */
`timescale 1ns/1ps

`define CHK(got, want) \
    begin \
        comparisons++; \
        if ((got) !== (want)) \
        begin \
            err_count++; \
            $display("[FAIL] %0t got %h want %h", $time, got, want); \
        end \
    end

module test_synth_serial_config_registers;
    // Reserved bits above the code are a plain default of our own.
    localparam logic [31:0] FIXED_WORD_8  = 32'h0000_0008;
    localparam logic [31:0] FIXED_WORD_11 = 32'h0000_000b;

    logic              MCLK_I = 1'b0;    // System clock.
    logic              RST_N_I = 1'b0;   // Reset, active low.
    logic              SER_CLK_I;        // Serial clock from host.
    logic              SER_DATA_I;       // Serial data from host.
    logic              LATCH_STROBE_I;   // Strobe from host.
    logic [12:0][31:0] ACTIVE_WORDS_O;   // Words in effect.
    logic              WORD_TAKEN_O;     // Accept pulse.
    logic              AUTOCAL_START_O;  // Calibration pulse.
    logic [13:0]       AUX_FRAC_O;       // Aux numerator.
    logic [7:0]        BAND_SEL_TIME_O;  // Band select time.
    logic [9:0]        LOCK_TIMEOUT_O;   // Lock timeout.
    logic [4:0]        ALC_WAIT_O;       // Level wait.
    logic [4:0]        SYNTH_WAIT_O;     // Synth lock wait.
    logic [7:0]        CONV_CLK_DIV_O;   // Converter divider.
    logic              CONV_ENABLE_O;    // Converter enable.
    logic              CONV_REQUEST_O;   // Conversion request.
    logic [19:0]       RESYNC_CLOCK_O;   // Resync timer.
    int                err_count = 0;    // Mismatches seen.
    int                comparisons = 0;  // Comparisons made.
    integer            seed = 73103;     // Fixed seed for repeatability.
    logic [31:0]       w;                // Word being sent.
    logic [12:0][31:0] exp_w;            // Expected active words.
    logic [12:0][31:0] sh_w;             // Expected shadow stage.

    // Free running 125 MHz clock.
    always #4 MCLK_I = ~MCLK_I;

    sscr_top sscr_top_i
    (
        .MCLK_I          (MCLK_I),
        .RST_N_I         (RST_N_I),
        .SER_CLK_I       (SER_CLK_I),
        .SER_DATA_I      (SER_DATA_I),
        .LATCH_STROBE_I  (LATCH_STROBE_I),
        .ACTIVE_WORDS_O  (ACTIVE_WORDS_O),
        .WORD_TAKEN_O    (WORD_TAKEN_O),
        .AUTOCAL_START_O (AUTOCAL_START_O),
        .AUX_FRAC_O      (AUX_FRAC_O),
        .BAND_SEL_TIME_O (BAND_SEL_TIME_O),
        .LOCK_TIMEOUT_O  (LOCK_TIMEOUT_O),
        .ALC_WAIT_O      (ALC_WAIT_O),
        .SYNTH_WAIT_O    (SYNTH_WAIT_O),
        .CONV_CLK_DIV_O  (CONV_CLK_DIV_O),
        .CONV_ENABLE_O   (CONV_ENABLE_O),
        .CONV_REQUEST_O  (CONV_REQUEST_O),
        .RESYNC_CLOCK_O  (RESYNC_CLOCK_O)
    );

    sscr_host_model sscr_host_model_i
    (
        .clk_i      (MCLK_I),
        .ser_clk_o  (SER_CLK_I),
        .ser_data_o (SER_DATA_I),
        .strobe_o   (LATCH_STROBE_I)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Updates the expected words for one latched word.
    function automatic void predict(input logic [31:0] wd);
        logic [3:0]  c;
        logic [31:0] m;
        c = wd[3:0];
        if (c > 4'hc)
            return;
        m = sscr_pkg::DB_MASK[c];
        // The divider select waits only while word 4 bit 14 is set.
        if (c == 4'h6 && exp_w[4][14])
            m = m | sscr_pkg::DBB_MASK;
        exp_w[c] = (exp_w[c] & m) | (wd & ~m);
        sh_w[c]  = wd;
        // A word 0 commits every pending shadowed bit.
        if (c == 4'h0)
            for (int r = 1; r < 13; r++)
            begin
                m = sscr_pkg::DB_MASK[r];
                if (r == 6)
                    m = m | sscr_pkg::DBB_MASK;
                exp_w[r] = (exp_w[r] & ~m) | (sh_w[r] & m);
            end
    endfunction

    // Compares every field output with the expected active words.
    task automatic check_fields();
        `CHK(ACTIVE_WORDS_O, exp_w);
        `CHK(AUX_FRAC_O, exp_w[2][31:18]);
        `CHK(BAND_SEL_TIME_O, exp_w[9][31:24]);
        `CHK(LOCK_TIMEOUT_O, exp_w[9][23:14]);
        `CHK(ALC_WAIT_O, exp_w[9][13:9]);
        `CHK(SYNTH_WAIT_O, exp_w[9][8:4]);
        `CHK(CONV_CLK_DIV_O, exp_w[10][13:6]);
        `CHK(CONV_REQUEST_O, exp_w[10][5]);
        `CHK(CONV_ENABLE_O, exp_w[10][4]);
        `CHK(RESYNC_CLOCK_O, exp_w[12][31:12]);
    endtask

    // Sends one word and watches for its accept pulse, bounded.
    task automatic put(input logic [31:0] wd);
        logic seen;
        logic valid;
        logic auto_exp;
        seen     = 1'b0;
        valid    = (wd[3:0] <= 4'hc);
        auto_exp = (wd[3:0] == 4'h0) && wd[21];
        predict(wd);
        fork
            sscr_host_model_i.send_word(wd);
            for (int k = 0; k < 300 && !seen; k++)
            begin
                @(posedge MCLK_I);
                #1;
                if (WORD_TAKEN_O === 1'b1)
                begin
                    seen = 1'b1;
                    `CHK(AUTOCAL_START_O, auto_exp);
                    `CHK(ACTIVE_WORDS_O, exp_w);
                end
            end
        join
        `CHK(seen, valid);
        // A valid word with no pulse means the port hung.
        if (valid && !seen)
            conclude();
        repeat (2) @(posedge MCLK_I);
        #1;
        check_fields();
    endtask

    // Holds reset for six cycles and checks the cleared outputs.
    task automatic do_reset();
        RST_N_I <= 1'b0;
        repeat (5) @(posedge MCLK_I);
        #1;
        `CHK(ACTIVE_WORDS_O, '0);
        `CHK(WORD_TAKEN_O, 1'b0);
        @(posedge MCLK_I);
        RST_N_I <= 1'b1;
        exp_w = '0;
        sh_w  = '0;
    endtask

    // Main sequence: every code, buffering corners, patterns, random.
    initial
    begin
        do_reset();
        for (int c = 0; c < 16; c++)
        begin
            w = $random(seed);
            w[3:0] = c[3:0];
            put(w);
        end
        // Divider select with conditional buffering on, then off.
        for (int b = 0; b < 2; b++)
        begin
            w = $random(seed);
            w[3:0] = 4'h4;
            w[14] = ~b[0];
            put(w);
            w = $random(seed);
            w[3:0] = 4'h6;
            put(w);
            w = $random(seed);
            w[3:0] = 4'h0;
            put(w);
        end
        put(FIXED_WORD_8);
        put(FIXED_WORD_11);
        for (int n = 0; n < 40; n++)
        begin
            w = $random(seed);
            put(w);
        end
        // A second reset in mid-run must clear every word again.
        do_reset();
        w = $random(seed);
        w[3:0] = 4'h0;
        put(w);
        conclude();
    end
endmodule
